// File: inc/bca_pkg.sv
// Purpose: constants for the battery capacity accounting core
// Assumes: 16-bit capacity counts, signed microvolt sense samples
// Notes:   temperatures are signed whole degrees Celsius
package bca_pkg;
	localparam int CAP_W = 16;
	localparam int SENSE_W = 16;
	localparam int TEMP_W = 8;
	localparam int DCR_W = 8;
	// register map
	localparam logic [6:0] ADDR_FLAGS = 7'h01;
	localparam logic [6:0] ADDR_NAC_HI = 7'h03;
	localparam logic [6:0] ADDR_LMD = 7'h05;
	localparam logic [6:0] ADDR_CPI = 7'h09;
	localparam logic [6:0] ADDR_VSB = 7'h0b;
	localparam logic [6:0] ADDR_RATE_TEMP_COMPENSATED_CAPACITY = 7'h0d;
	localparam logic [6:0] ADDR_RATE_COMPENSATED_CAPACITY = 7'h0e;
	localparam logic [6:0] ADDR_MAXV = 7'h15;
	localparam logic [6:0] ADDR_NAC_LO = 7'h17;
	localparam logic [6:0] ADDR_DCR = 7'h18;
	localparam logic [6:0] ADDR_RESET = 7'h39;
	localparam logic [7:0] MAXV_RESET = 8'hFF;
	localparam logic [7:0] RESET_CMD_BIT = 8'h80;
	// flag register bit positions
	localparam int FLAG_CHGS = 7;
	localparam int FLAG_BRP = 6;
	localparam int FLAG_PROTECTOR_STATE_INPUT = 5;
	localparam int FLAG_CI = 4;
	localparam int FLAG_VDQ = 3;
	localparam logic [7:0] FLAG_FIXED = 8'h04; // bit 2 reads one
	// thresholds
	localparam logic signed [SENSE_W-1:0] SENSE_THRESH_UV = 16'sd250;
	localparam logic signed [TEMP_W-1:0] T_LOW = 8'sd0;
	localparam logic signed [TEMP_W-1:0] T_HIGH = 8'sd60;
	localparam logic signed [TEMP_W-1:0] T_COLD = -8'sd20;
	localparam logic signed [TEMP_W-1:0] T_COOL = 8'sd10;
	localparam logic [7:0] CPI_MAX = 8'hFF;
	localparam logic [7:0] CPI_CI_LIMIT = 8'h40;
	localparam logic [1:0] VALID_CHARGE_UPDATES = 2'h2;
	// self-discharge timing
	localparam longint DAY_S = 86400;
	localparam longint CLK_HZ = 100_000_000;
	localparam longint DAY_CYCLES = DAY_S * CLK_HZ;
	localparam logic [3:0] SD_BASE_SHIFT = 4'h9; // 512 at 20-30 C
endpackage : bca_pkg

// File: core/bca_comp.sv
// Purpose: compensated capacity from nominal count and reductions
// Assumes: reduction fractions in 1/100 of learned capacity
// Notes:   purely combinational
`timescale 1ns/100ps
module bca_comp
	import bca_pkg::*;
(
	input  wire logic [CAP_W-1:0]        nominal,
	input  wire logic [CAP_W-1:0]        learned,
	input  wire logic                    rateHeld,
	input  wire logic                    cokeAnode,
	input  wire logic signed [TEMP_W-1:0] temperature,
	output logic      [CAP_W-1:0]        rateComp,
	output logic      [CAP_W-1:0]        rateTempComp
);
	logic [6:0] ratePct;
	logic [6:0] tempPct;
	logic [CAP_W+6:0] rateProd;
	logic [CAP_W+6:0] tempProd;
	logic [CAP_W-1:0] rateRed;
	logic [CAP_W-1:0] tempRed;
	logic [CAP_W-1:0] sumRed;
	assign ratePct = !rateHeld ? 7'd0 : (cokeAnode ? 7'd10 : 7'd5);
	assign tempPct = (temperature >= T_COOL) ? 7'd0 :
		(temperature > T_LOW) ? (cokeAnode ? 7'd10 : 7'd5) :
		(temperature > T_COLD) ? (cokeAnode ? 7'd30 : 7'd15) :
		(cokeAnode ? 7'd60 : 7'd37);
	assign rateProd = learned * ratePct;
	assign tempProd = learned * tempPct;
	assign rateRed = CAP_W'(rateProd / 100);
	assign tempRed = CAP_W'(tempProd / 100);
	assign sumRed = (rateRed > ~tempRed) ? {CAP_W{1'b1}} : CAP_W'(rateRed + tempRed);
	assign rateComp = (nominal > rateRed) ? CAP_W'(nominal - rateRed) : '0;
	assign rateTempComp = (nominal > sumRed) ? CAP_W'(nominal - sumRed) : '0;
endmodule : bca_comp

// File: core/bca_core.sv
// Contract
// - below discharge threshold each count lowers nominal, raises discharge counter
// - self-discharge lowers nominal once per period and raises discharge counter
// - compensated values come from nominal by rate, temperature, anode factor
// - graphite rate reduction zero below 0.5C, 5 percent at or above
// - graphite temperature reduction 0, 5, 15, 37 percent by band
// - coke rate reduction zero below 0.5C, 10 percent at or above
// - coke temperature reduction 0, 10, 30, 60 percent by band
// - high-rate reduction holds until a valid charge
// - display source is the rate and temperature compensated value
// - charging below 0 C caps nominal at 94 percent of learned
// - nominal self-discharge nominal/512 per day at 20 to 30 C
// - self-discharge divisor 2048 down to 16 over eight bands
// - anode select high disables self-discharge
// - no counting between thresholds of 250 microvolts
// - charge FET low on overvoltage or temperature outside 0 to 60 C
// - protector bit set above 2.5V, cleared below 0.5V
// - register 15h holds the maximum stack voltage limit
// - inaccuracy counter counts valid charges, clears on learn, saturates 255
// - inaccurate flag set after 64 valid charges without learning
// - nominal counts up to learned, down to zero
// - discharge counter clears at full, saturates at maximum
// - charge counts only above the charge threshold
//
// Purpose: charge bookkeeping, compensation and pack supervision
// Assumes: front end gives count strobes with offset-corrected sense samples
// Notes:   register port is a plain byte read/write strobe interface
`timescale 1ns/100ps
module bca_core
	import bca_pkg::*;
#(
	parameter longint SD_PERIOD     = DAY_CYCLES,
	parameter logic [CAP_W-1:0] PFC = 16'h7800
)(
	input  wire logic                      ref_clk,
	input  wire logic                      reset,
	input  wire logic                      countStrobe,
	input  wire logic signed [SENSE_W-1:0] offsetCorrectedSenseVoltage,
	input  wire logic [CAP_W-1:0]          countStep,
	input  wire logic                      highRate,
	input  wire logic signed [TEMP_W-1:0]  temperature,
	input  wire logic [7:0]                batteryVoltageSample,
	input  wire logic                      anodeSelectHigh,
	input  wire logic                      anodeSelectLow,
	input  wire logic                      protectorAbove2v5,
	input  wire logic                      protectorBelow0v5,
	input  wire logic                      learnRequest,
	input  wire logic                      regWrite,
	input  wire logic                      regRead,
	input  wire logic [6:0]                regAddr,
	input  wire logic [7:0]                regWdata,
	output logic      [7:0]                regRdata,
	output logic                           chargeFetControl,
	output logic      [CAP_W-1:0]          displayCapacity
);
	logic [CAP_W-1:0] nominalCapacityCount;
	logic [CAP_W-1:0] learnedFullCapacity;
	logic [DCR_W-1:0] dischargeCounter;
	logic [7:0]       inaccuracyChargeCounter;
	logic [7:0]       maxStackVoltageLimit;
	logic             cokeAnode;
	logic             sdDisabled;
	logic             rateHeld;
	logic             chargeStatus;
	logic             batteryReplaced;
	logic             protectorState;
	logic             validDischargeFlag;
	logic [1:0]       chargeUpdates;
	logic [63:0]      sdTimer;
	logic [2:0]       aHighSync;
	logic [2:0]       aLowSync;
	logic [2:0]       pHighSync;
	logic [2:0]       pLowSync;
	logic [1:0]       initCount;
	logic [CAP_W-1:0] rateCompensatedCapacity;
	logic [CAP_W-1:0] rateTempCompensatedCapacity;

	// three-stage pin synchronisers
	always_ff @(posedge ref_clk) begin
		aHighSync <= {aHighSync[1:0], anodeSelectHigh};
		aLowSync <= {aLowSync[1:0], anodeSelectLow};
		pHighSync <= {pHighSync[1:0], protectorAbove2v5};
		pLowSync <= {pLowSync[1:0], protectorBelow0v5};
	end
	wire aHighStable = aHighSync[2] & aHighSync[1];
	wire aLowStable = aLowSync[2] & aLowSync[1];
	wire pHighStable = pHighSync[2] & pHighSync[1];
	wire pLowStable = pLowSync[2] & pLowSync[1];

	// activity decode
	wire softReset = regWrite && (regAddr == ADDR_RESET) && (regWdata & RESET_CMD_BIT) != 8'h00;
	wire chargeActive = offsetCorrectedSenseVoltage > SENSE_THRESH_UV;
	wire dischargeActive = offsetCorrectedSenseVoltage < -SENSE_THRESH_UV;
	wire chargeCount = countStrobe && chargeActive;
	wire dischargeCount = countStrobe && dischargeActive;
	wire [CAP_W+6:0] capProd = learnedFullCapacity * 7'd94;
	wire [CAP_W-1:0] chargeCeiling = (temperature < T_LOW) ?
		CAP_W'(capProd / 100) : learnedFullCapacity;
	wire [CAP_W:0] upSum = {1'b0, nominalCapacityCount} + {1'b0, countStep};
	// count up clamped to the ceiling
	wire [CAP_W-1:0] chargedValue = (upSum > {1'b0, chargeCeiling}) ?
		chargeCeiling : upSum[CAP_W-1:0];
	wire [CAP_W-1:0] dischargedValue = (nominalCapacityCount > countStep) ?
		CAP_W'(nominalCapacityCount - countStep) : '0;
	wire validChargeEvent = chargeCount && (chargeUpdates == VALID_CHARGE_UPDATES - 2'h1);

	wire signed [TEMP_W-1:0] tBand = TEMP_W'(temperature / 10);
	wire [3:0] sdShift = (temperature < T_COOL) ? 4'hB :
		(temperature > 8'sd70) ? 4'h4 :
		4'(SD_BASE_SHIFT + 4'h2 - 4'(tBand));
	wire [CAP_W-1:0] sdAmount = nominalCapacityCount >> sdShift;
	wire sdTick = (sdTimer == 64'(SD_PERIOD - 1));
	wire sdEvent = sdTick && !sdDisabled && (sdAmount != '0);

	// init and strap sampling on the second edge after release, once the
	// synchroniser is full; self-discharge stays off until the strap is known
	// anode type taken at initialisation
	always_ff @(posedge ref_clk) begin
		if (reset || softReset) begin
			initCount <= 2'h2;
			cokeAnode <= 1'b1;
			sdDisabled <= 1'b1;
		end else if (initCount != 2'h0) begin
			initCount <= initCount - 2'h1;
			if (initCount == 2'h1) begin
				cokeAnode <= !aLowStable;
				sdDisabled <= aHighStable;
			end
		end
	end

	// self-discharge timer, one tick per period
	always_ff @(posedge ref_clk) begin
		if (reset || sdTick)
			sdTimer <= '0;
		else
			sdTimer <= sdTimer + 64'd1;
	end

	// nominal capacity counter
	// charge, discharge and self-discharge
	always_ff @(posedge ref_clk) begin
		if (reset || softReset)
			nominalCapacityCount <= '0;
		else if (regWrite && regAddr == ADDR_NAC_HI)
			nominalCapacityCount <= {regWdata, nominalCapacityCount[7:0]};
		else if (regWrite && regAddr == ADDR_NAC_LO)
			nominalCapacityCount <= {nominalCapacityCount[15:8], regWdata};
		else if (chargeCount && nominalCapacityCount < chargeCeiling)
			nominalCapacityCount <= chargedValue;
		else if (dischargeCount)
			nominalCapacityCount <= dischargedValue;
		else if (sdEvent)
			nominalCapacityCount <= CAP_W'(nominalCapacityCount - sdAmount);
	end

	// discharge counter
	// clear at full, saturate at top
	always_ff @(posedge ref_clk) begin
		if (reset || softReset || nominalCapacityCount == learnedFullCapacity)
			dischargeCounter <= '0;
		else if (regWrite && regAddr == ADDR_DCR)
			dischargeCounter <= regWdata;
		else if ((dischargeCount || (sdEvent && nominalCapacityCount != '0))
				&& dischargeCounter != {DCR_W{1'b1}})
			dischargeCounter <= dischargeCounter + 8'd1;
	end

	// learned capacity, loaded from discharge counter on request
	always_ff @(posedge ref_clk) begin
		if (reset || softReset)
			learnedFullCapacity <= PFC;
		else if (regWrite && regAddr == ADDR_LMD)
			learnedFullCapacity <= {regWdata, 8'h00};
		else if (learnRequest && validDischargeFlag)
			learnedFullCapacity <= {dischargeCounter, 8'h00};
	end

	// valid charge qualification and charge status
	always_ff @(posedge ref_clk) begin
		if (reset || softReset || dischargeCount || !chargeActive)
			chargeUpdates <= '0;
		else if (chargeCount && chargeUpdates != VALID_CHARGE_UPDATES)
			chargeUpdates <= chargeUpdates + 2'h1;
	end
	always_ff @(posedge ref_clk) begin
		if (reset || softReset)
			chargeStatus <= 1'b0;
		else
			chargeStatus <= chargeActive && !dischargeActive;
	end

	// high-rate reduction held until valid charge
	always_ff @(posedge ref_clk) begin
		if (reset || softReset || validChargeEvent)
			rateHeld <= 1'b0;
		else if (dischargeCount && highRate)
			rateHeld <= 1'b1;
	end

	// valid discharge qualification, blocked by a cold charge
	always_ff @(posedge ref_clk) begin
		if (reset || softReset)
			validDischargeFlag <= 1'b0;
		else if (nominalCapacityCount == learnedFullCapacity && temperature >= T_LOW)
			validDischargeFlag <= 1'b1;
		else if (validChargeEvent || learnRequest)
			validDischargeFlag <= 1'b0;
	end

	// battery replaced flag
	always_ff @(posedge ref_clk) begin
		if (reset || softReset)
			batteryReplaced <= 1'b1;
		else if (chargeCount && chargedValue == learnedFullCapacity)
			batteryReplaced <= 1'b0;
	end

	// inaccuracy counter, learn clear beats increment
	always_ff @(posedge ref_clk) begin
		if (reset || softReset || (learnRequest && validDischargeFlag))
			inaccuracyChargeCounter <= '0;
		else if (regWrite && regAddr == ADDR_CPI)
			inaccuracyChargeCounter <= regWdata;
		else if (validChargeEvent && inaccuracyChargeCounter != CPI_MAX)
			inaccuracyChargeCounter <= inaccuracyChargeCounter + 8'd1;
	end
	wire capacityInaccurateFlag = inaccuracyChargeCounter >= CPI_CI_LIMIT;

	always_ff @(posedge ref_clk) begin
		if (reset)
			protectorState <= 1'b0;
		else if (pHighStable)
			protectorState <= 1'b1;
		else if (pLowStable)
			protectorState <= 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			maxStackVoltageLimit <= MAXV_RESET;
		else if (regWrite && regAddr == ADDR_MAXV)
			maxStackVoltageLimit <= regWdata;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			chargeFetControl <= 1'b0;
		else
			chargeFetControl <= !(batteryVoltageSample > maxStackVoltageLimit
				|| temperature < T_LOW || temperature > T_HIGH);
	end

	// compensation
	bca_comp u_comp (
		.nominal      (nominalCapacityCount),
		.learned      (learnedFullCapacity),
		.rateHeld     (rateHeld),
		.cokeAnode    (cokeAnode),
		.temperature  (temperature),
		.rateComp     (rateCompensatedCapacity),
		.rateTempComp (rateTempCompensatedCapacity)
	);

	always_ff @(posedge ref_clk) begin
		if (reset)
			displayCapacity <= '0;
		else
			displayCapacity <= rateTempCompensatedCapacity;
	end

	// register read mux, registered
	wire [7:0] flagByte = FLAG_FIXED | {chargeStatus, batteryReplaced, protectorState,
		capacityInaccurateFlag, validDischargeFlag, 3'b000};
	wire [7:0] readMux =
		(regAddr == ADDR_FLAGS)  ? flagByte :
		(regAddr == ADDR_NAC_HI) ? nominalCapacityCount[15:8] :
		(regAddr == ADDR_NAC_LO) ? nominalCapacityCount[7:0] :
		(regAddr == ADDR_LMD)    ? learnedFullCapacity[15:8] :
		(regAddr == ADDR_CPI)    ? inaccuracyChargeCounter :
		(regAddr == ADDR_VSB)    ? batteryVoltageSample :
		(regAddr == ADDR_RATE_TEMP_COMPENSATED_CAPACITY)   ? rateTempCompensatedCapacity[15:8] :
		(regAddr == ADDR_RATE_COMPENSATED_CAPACITY)   ? rateCompensatedCapacity[15:8] :
		(regAddr == ADDR_MAXV)   ? maxStackVoltageLimit :
		(regAddr == ADDR_DCR)    ? dischargeCounter : 8'h00;
	always_ff @(posedge ref_clk) begin
		if (reset)
			regRdata <= 8'h00;
		else if (regRead)
			regRdata <= readMux;
	end
endmodule : bca_core

// File: bench/bca_core_monitor.sv
// Purpose: port-level checks of the capacity accounting core
// Assumes: one clock, synchronous active-high reset
// Notes:   bound from the bench top file
`timescale 1ns/100ps
module bca_core_mon
	import bca_pkg::*;
(
	input wire logic                     ref_clk,
	input wire logic                     reset,
	input wire logic signed [TEMP_W-1:0] temperature,
	input wire logic [7:0]               batteryVoltageSample,
	input wire logic                     regWrite,
	input wire logic                     regRead,
	input wire logic [6:0]               regAddr,
	input wire logic [7:0]               regWdata,
	input wire logic [7:0]               regRdata,
	input wire logic                     chargeFetControl,
	input wire logic [CAP_W-1:0]         displayCapacity
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// charging window open and stack voltage at its lowest
	wire logic inWindow = temperature >= T_LOW && temperature <= T_HIGH
		&& batteryVoltageSample == 8'h00;
	// limit write followed at once by a limit read
	sequence s_limitWrite; regWrite && regAddr == ADDR_MAXV; endsequence
	sequence s_limitRead; regRead && regAddr == ADDR_MAXV; endsequence
	property p_resetClear;
		@(posedge ref_clk) disable iff (1'b0)
		reset |=> regRdata == 8'h00 && !chargeFetControl && displayCapacity == 16'h0000;
	endproperty
	chk_fet_hot: assert property (temperature > T_HIGH && $past(temperature) > T_HIGH |-> !chargeFetControl)
		else $error("charge fet on above high limit");
	chk_fet_cold: assert property (temperature < T_LOW [*3] |-> !chargeFetControl)
		else $error("charge fet on below low limit");
	chk_fet_window: assert property (inWindow [*3] |-> chargeFetControl)
		else $error("charge fet off inside window");
	chk_limit_readback: assert property (s_limitWrite ##1 s_limitRead |=> regRdata == $past(regWdata, 2))
		else $error("limit register lost written value");
	chk_unmapped_zero: assert property (regRead && regAddr == 7'h7F |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	chk_flag_fixed: assert property (regRead && regAddr == ADDR_FLAGS |=> regRdata[2] == 1'b1)
		else $error("flag bit two not one");
	chk_read_holds: assert property (!regRead |=> $stable(regRdata))
		else $error("read data moved without read");
	chk_reset_clear: assert property (p_resetClear)
		else $error("outputs not cleared by reset");
endmodule : bca_core_mon

// File: bench/bca_fe_model.sv
// Purpose: measurement front end feeding count strobes and levels
// Assumes: caller sits just after a falling clock edge
// Notes:   sense sample holds between strobes for the level flags
`timescale 1ns/100ps
module bca_fe_model
	import bca_pkg::*;
(
	input  wire logic                      ref_clk,
	output logic                           countStrobe,
	output logic signed [SENSE_W-1:0]      offsetCorrectedSenseVoltage,
	output logic [CAP_W-1:0]               countStep,
	output logic                           highRate,
	output logic signed [TEMP_W-1:0]       temperature,
	output logic [7:0]                     batteryVoltageSample
);
	// quiet front end at room temperature
	initial begin
		countStrobe = 1'b0;
		offsetCorrectedSenseVoltage = 16'sh0000;
		countStep = 16'h0000;
		highRate = 1'b0;
		temperature = 8'sh19;
		batteryVoltageSample = 8'h00;
	end
	// one count, then a strobe-free cycle so back-to-back calls never glitch
	task automatic count(input logic signed [SENSE_W-1:0] v, input logic [CAP_W-1:0] s);
		countStrobe = 1'b1;
		offsetCorrectedSenseVoltage = v;
		countStep = s;
		@(negedge ref_clk);
		countStrobe = 1'b0;
		@(negedge ref_clk);
	endtask : count
	// slow environment levels
	task automatic env(input logic signed [TEMP_W-1:0] t, input logic h, input logic [7:0] b);
		temperature = t;
		highRate = h;
		batteryVoltageSample = b;
	endtask : env
endmodule : bca_fe_model

// File: bench/test_battery_capacity_accounting.sv
// Purpose: self-checking bench of the capacity accounting core
// Assumes: coke strap with self-discharge off, then graphite after a reset
// Notes:   all stimulus moves on falling edges
`timescale 1ns/100ps
module test_battery_capacity_accounting
	import bca_pkg::*;
;
	`define CHK(a, b) tests_run++; if ((a) !== (b)) begin n_errors++; \
		$display("Error %0t ns: got %h want %h", $time, (a), (b)); end
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [6:0] regAddr = 7'h00;
	logic [7:0] regWdata = 8'h00;
	logic protectorAbove2v5 = 1'b0;
	logic protectorBelow0v5 = 1'b1;
	logic anodeSelectHigh = 1'b1;
	logic anodeSelectLow = 1'b0;
	logic countStrobe, highRate, chargeFetControl;
	logic signed [SENSE_W-1:0] offsetCorrectedSenseVoltage;
	logic signed [TEMP_W-1:0] temperature;
	logic [CAP_W-1:0] countStep, displayCapacity;
	logic [7:0] batteryVoltageSample, regRdata;
	int n_errors = 0;
	int tests_run = 0;
	always #5 ref_clk = ~ref_clk;
	bca_fe_model u_fe (.ref_clk(ref_clk), .countStrobe(countStrobe),
		.offsetCorrectedSenseVoltage(offsetCorrectedSenseVoltage), .countStep(countStep),
		.highRate(highRate), .temperature(temperature),
		.batteryVoltageSample(batteryVoltageSample));
	bca_core #(.SD_PERIOD(32'h0000_0064), .PFC(16'h7800)) u_dut (.ref_clk(ref_clk),
		.reset(reset), .countStrobe(countStrobe),
		.offsetCorrectedSenseVoltage(offsetCorrectedSenseVoltage), .countStep(countStep),
		.highRate(highRate), .temperature(temperature),
		.batteryVoltageSample(batteryVoltageSample), .anodeSelectHigh(anodeSelectHigh),
		.anodeSelectLow(anodeSelectLow), .protectorAbove2v5(protectorAbove2v5),
		.protectorBelow0v5(protectorBelow0v5), .learnRequest(1'b0), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.chargeFetControl(chargeFetControl), .displayCapacity(displayCapacity));
	// register strobes, one cycle each
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge ref_clk);
		regWrite = 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		regRead = 1'b1;
		regAddr = a;
		@(negedge ref_clk);
		regRead = 1'b0;
		@(negedge ref_clk);
		d = regRdata;
	endtask : rd
	// reset values, limit write, unmapped place
	task automatic t_regs();
		logic [7:0] d;
		rd(ADDR_MAXV, d); `CHK(d, MAXV_RESET)
		wr(ADDR_MAXV, 8'h80); rd(ADDR_MAXV, d); `CHK(d, 8'h80)
		rd(7'h7F, d); `CHK(d, 8'h00)
		rd(ADDR_FLAGS, d); `CHK(d & FLAG_FIXED, FLAG_FIXED)
		rd(ADDR_NAC_HI, d); `CHK(d, 8'h00)
	endtask : t_regs
	// cold ceiling, filter edges, full stop, discharge
	task automatic t_count();
		logic [7:0] d;
		u_fe.env(-8'sh05, 1'b0, 8'h00);
		repeat (8) u_fe.count(16'sh03E8, 16'h1000);
		rd(ADDR_NAC_HI, d); `CHK(d, 8'h70)
		u_fe.count(16'sh00FA, 16'h1000);
		u_fe.count(-16'sh00FA, 16'h1000);
		rd(ADDR_NAC_HI, d); `CHK(d, 8'h70)
		u_fe.env(8'sh19, 1'b0, 8'h00);
		u_fe.count(16'sh03E8, 16'h1000);
		rd(ADDR_NAC_HI, d); `CHK(d, 8'h78)
		u_fe.count(-16'sh03E8, 16'h4800);
		rd(ADDR_NAC_HI, d); `CHK(d, 8'h30)
		rd(ADDR_NAC_LO, d); `CHK(d, 8'h00)
	endtask : t_count
	// coke reductions on 0x3000 with learned 0x7800
	task automatic t_comp();
		logic signed [7:0] t [6] = '{8'sh19, 8'sh19, 8'sh19, 8'sh05, -8'sh0A, -8'sh19};
		logic h [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		logic [15:0] e [6] = '{16'h3000, 16'h2400, 16'h2400, 16'h1800, 16'h0000, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			u_fe.env(t[i], h[i], 8'h00);
			// a high-rate discharge count of zero size arms the rate reduction
			if (h[i])
				u_fe.count(-16'sh03E8, 16'h0000);
			repeat (5) @(negedge ref_clk);
			`CHK(displayCapacity, e[i])
		end
		u_fe.env(8'sh19, 1'b0, 8'h00);
		repeat (2) u_fe.count(16'sh03E8, 16'h0010);
		repeat (5) @(negedge ref_clk);
		`CHK(displayCapacity, 16'h3020)
	endtask : t_comp
	// temperature edges and limit 0x80 against the stack sample
	task automatic t_fet();
		logic signed [7:0] t [6] = '{8'sh3D, 8'sh3C, -8'sh01, 8'sh00, 8'sh19, 8'sh19};
		logic [7:0] v [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h80};
		logic e [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 6; i++) begin
			u_fe.env(t[i], 1'b0, v[i]);
			repeat (4) @(negedge ref_clk);
			`CHK(chargeFetControl, e[i])
		end
		u_fe.env(8'sh19, 1'b0, 8'h00);
	endtask : t_fet
	// protector pin levels to flag bit five
	task automatic t_prot();
		logic [7:0] d;
		protectorBelow0v5 = 1'b0;
		protectorAbove2v5 = 1'b1;
		repeat (8) @(negedge ref_clk);
		rd(ADDR_FLAGS, d); `CHK(d[FLAG_PROTECTOR_STATE_INPUT], 1'b1)
		protectorAbove2v5 = 1'b0;
		protectorBelow0v5 = 1'b1;
		repeat (8) @(negedge ref_clk);
		rd(ADDR_FLAGS, d); `CHK(d[FLAG_PROTECTOR_STATE_INPUT], 1'b0)
		rd(ADDR_NAC_LO, d); `CHK(d, 8'h20)
	endtask : t_prot
	// graphite strap after a mid-run reset: reductions, self-discharge, inaccuracy
	task automatic t_graphite();
		logic [7:0] d;
		anodeSelectHigh = 1'b0;
		anodeSelectLow = 1'b1;
		reset = 1'b1;
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		repeat (2) @(negedge ref_clk);
		wr(ADDR_NAC_HI, 8'h30);
		u_fe.env(8'sh05, 1'b1, 8'h00);
		u_fe.count(-16'sh03E8, 16'h0000);
		repeat (5) @(negedge ref_clk);
		`CHK(displayCapacity, 16'h2400)
		rd(ADDR_RATE_COMPENSATED_CAPACITY, d); `CHK(d, 8'h2A)
		u_fe.env(-8'sh0A, 1'b0, 8'h00);
		repeat (5) @(negedge ref_clk);
		`CHK(displayCapacity, 16'h1800)
		u_fe.env(-8'sh19, 1'b0, 8'h00);
		repeat (5) @(negedge ref_clk);
		`CHK(displayCapacity, 16'h0000)
		u_fe.env(8'sh19, 1'b0, 8'h00);
		repeat (100) @(negedge ref_clk);
		rd(ADDR_NAC_LO, d); `CHK(d, 8'hE8)
		rd(ADDR_DCR, d); `CHK(d, 8'h02)
		wr(ADDR_CPI, 8'h3F);
		repeat (2) u_fe.count(16'sh03E8, 16'h0000);
		rd(ADDR_CPI, d); `CHK(d, 8'h40)
		rd(ADDR_FLAGS, d); `CHK(d[FLAG_CI], 1'b1)
		wr(ADDR_CPI, 8'hFF);
		u_fe.count(-16'sh03E8, 16'h0000);
		repeat (2) u_fe.count(16'sh03E8, 16'h0000);
		rd(ADDR_CPI, d); `CHK(d, 8'hFF)
	endtask : t_graphite
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	// main sequence after two reset cycles
	initial begin
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		@(negedge ref_clk);
		t_regs();
		t_count();
		t_comp();
		t_fet();
		t_prot();
		t_graphite();
		stop_test();
	end
	// watchdog; the sequence needs well under a thousand cycles
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
endmodule : test_battery_capacity_accounting
bind bca_core bca_core_mon u_mon (.ref_clk(ref_clk), .reset(reset), .temperature(temperature),
	.batteryVoltageSample(batteryVoltageSample), .regWrite(regWrite), .regRead(regRead),
	.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
	.chargeFetControl(chargeFetControl), .displayCapacity(displayCapacity));
